// ### rtl/qr_pkg.sv
package qr_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int EDGE_BLANK_NS = 330;
  localparam int MAX_ON_NS = 30_000;
  localparam int MIN_SWITCH_HZ = 20_000;
  localparam int SHORT_RS_NS = 2_500;
  localparam int LONG_RS_NS = 25_000;
  localparam int ENTRY_BLANK_MS = 24;
  localparam int BURST_TIMER_HZ = 52_000;
  localparam int WSHORT_BLANK_NS = 200;
  // Least times round up, longest times round down
  localparam int EDGE_BLANK_CYC =
    (EDGE_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_ON_CYC = MAX_ON_NS / CLK_PERIOD_NS;
  localparam int MAX_OFF_CYC = CLK_HZ / MIN_SWITCH_HZ;
  localparam int SHORT_RS_CYC =
    (SHORT_RS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LONG_RS_CYC =
    (LONG_RS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ENTRY_BLANK_CYC = ENTRY_BLANK_MS * (CLK_HZ / 1000);
  localparam int BURST_PERIOD_CYC = CLK_HZ / BURST_TIMER_HZ;
  localparam int BURST_DUTY_PCT = 50;
  localparam int WSHORT_BLANK_CYC =
    (WSHORT_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Valley counts and current limit codes
  // ---------------------------------------------------------------
  localparam logic [2:0] VALLEY_MAX = 3'h7;
  localparam logic [2:0] BURST_ENTRY_VALLEY_COUNT = 3'h7;
  localparam logic [2:0] TARGET_RESET = 3'h1;
  localparam logic [7:0] LIMIT_FULL = 8'hff;
  localparam int BURST_LIMIT_PCT = 34;
  localparam logic [7:0] BURST_LIMIT =
    8'((int'(LIMIT_FULL) * BURST_LIMIT_PCT) / 100);
  localparam logic [7:0] FOLD_FIRST_STEP = 8'h20;
  localparam int FOLD_STEP_SHIFT = 4;

  // Nonlinear foldback drop per step of excess current
  function automatic logic [7:0] fold_drop(input logic [2:0] step);
    case (step)
      3'h0: fold_drop = 8'h00;
      3'h1: fold_drop = 8'h10;
      3'h2: fold_drop = 8'h1e;
      3'h3: fold_drop = 8'h2a;
      3'h4: fold_drop = 8'h34;
      3'h5: fold_drop = 8'h3c;
      3'h6: fold_drop = 8'h42;
      default: fold_drop = 8'h46;
    endcase
  endfunction : fold_drop

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LIMIT = 8'h08;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_TGT_LSB = 1;
  localparam int CTRL_CLR_BIT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Switching states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RING = 3'b001,
    S_WAIT = 3'b010,
    S_ON = 3'b011,
    S_PAUSE = 3'b100,
    S_BURST_OFF = 3'b101,
    S_BURST_ON = 3'b110
  } sw_state_t;

endpackage : qr_pkg

// ### rtl/limit_if.sv
`timescale 1ns/1ps
// Foldback input, burst select and resulting limit code
interface limit_if;
  logic [7:0] zc_code;
  logic burst;
  logic [7:0] limit;
  modport src (output zc_code, output burst, input limit);
  modport lim (input zc_code, input burst, output limit);
endinterface : limit_if

// ### rtl/spike_filter.sv
`timescale 1ns/1ps
// Passes a level only after it has stood high for COUNT cycles
module spike_filter #(
  parameter int COUNT = 40,
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);
  localparam logic [W-1:0] LAST = W'(COUNT - 1);
  logic [W-1:0] cnt;
  wire at_end = (cnt == LAST);

  // Count consecutive high cycles, restart on any low
  always_ff @(posedge aclk) begin
    if (!aresetn || !din) begin
      cnt <= '0;
      dout <= 1'b0;
    end else begin
      if (!at_end) cnt <= cnt + 1'b1;
      dout <= at_end;
    end
  end
endmodule : spike_filter

// ### rtl/current_limit.sv
`timescale 1ns/1ps
// Foldback-corrected current limit code for the limit comparator
module current_limit (
  input wire logic aclk,
  input wire logic aresetn,
  limit_if.lim lif
);
  import qr_pkg::*;

  wire over = lif.zc_code > FOLD_FIRST_STEP;
  wire [7:0] excess = over ? 8'(lif.zc_code - FOLD_FIRST_STEP) : 8'h00;
  wire [7:0] raw_step = excess >> FOLD_STEP_SHIFT;
  wire [2:0] step = (raw_step > 8'h07) ? 3'h7 : raw_step[2:0];

  // Burst limit or full limit lowered in nonlinear steps
  always_ff @(posedge aclk) begin
    if (!aresetn) lif.limit <= LIMIT_FULL;
    else if (lif.burst) lif.limit <= BURST_LIMIT;
    else lif.limit <= LIMIT_FULL - fold_drop(step);
  end
endmodule : current_limit

// ### rtl/valley_switch_burst_control.sv
`timescale 1ns/1ps
module valley_switch_burst_control
  import qr_pkg::*;
#(
  parameter int MAX_ON = qr_pkg::MAX_ON_CYC,
  parameter int MAX_OFF = qr_pkg::MAX_OFF_CYC,
  parameter int LONG_RS = qr_pkg::LONG_RS_CYC,
  parameter int ENTRY_BLANK = qr_pkg::ENTRY_BLANK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [qr_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [qr_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Digitised comparator inputs
  input wire logic zc_falling,
  input wire logic zc_above_rs,
  input wire logic cs_over_fb,
  input wire logic cs_over_limit,
  input wire logic cs_over_short,
  input wire logic fb_below_entry,
  input wire logic fb_above_resume,
  input wire logic fb_above_pause,
  input wire logic fb_above_exit,
  input wire logic [7:0] zc_current_code,
  // Outputs
  output logic gate,
  output logic bias_enable,
  output logic [7:0] limit_code,
  output logic burst_active,
  output logic short_fault
);
  import qr_pkg::*;

  // -----------------------------------------------------------------
  // Cycle counts at counter width
  // -----------------------------------------------------------------
  localparam int CW = 16;
  localparam int EW = 24;
  localparam logic [CW-1:0] LEB_L = CW'(EDGE_BLANK_CYC);
  localparam logic [CW-1:0] MAX_ON_L = CW'(MAX_ON);
  localparam logic [CW-1:0] MAX_OFF_L = CW'(MAX_OFF);
  localparam logic [CW-1:0] SHORT_RS_L = CW'(SHORT_RS_CYC);
  localparam logic [CW-1:0] LONG_RS_L = CW'(LONG_RS);
  localparam logic [CW-1:0] PERIOD_L = CW'(BURST_PERIOD_CYC);
  localparam logic [CW-1:0] HALF_L =
    CW'((BURST_PERIOD_CYC * BURST_DUTY_PCT) / 100);
  localparam logic [CW-1:0] CNT_MAX = '1;

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  sw_state_t state;
  sw_state_t next_state;
  logic ctrl_enable;
  logic [2:0] target_valley;
  logic [2:0] valley_counter;
  logic [CW-1:0] on_cnt;
  logic [CW-1:0] off_cnt;
  logic [CW-1:0] tmr;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic short_seen;
  logic entry_ok;
  logic fault_clear;
  logic next_gate;
  logic next_bias;
  logic exit_evt;

  limit_if lif();

  // -----------------------------------------------------------------
  // Register bus decode
  // -----------------------------------------------------------------
  wire aw_hs = awvalid && awready;
  wire w_hs = wvalid && wready;
  wire ar_hs = arvalid && arready;
  wire write_go = !awready && !wready && !bvalid;
  wire wr_ctrl = write_go && (aw_addr == ADDR_CTRL);
  wire wr_status = write_go && (aw_addr == ADDR_STATUS);
  wire wr_limit = write_go && (aw_addr == ADDR_LIMIT);
  wire wr_mapped = wr_ctrl || wr_status || wr_limit;
  wire ctrl_lane = wr_ctrl && w_strb[0];
  wire rd_ctrl = (araddr == ADDR_CTRL);
  wire rd_status = (araddr == ADDR_STATUS);
  wire rd_limit = (araddr == ADDR_LIMIT);
  wire rd_mapped = rd_ctrl || rd_status || rd_limit;
  wire [31:0] ctrl_word = {27'h0, 1'b0, target_valley, ctrl_enable};
  wire [31:0] status_word = {22'h0, state, valley_counter,
                             short_fault, bias_enable, burst_active, gate};
  wire [31:0] limit_word = {24'h0, limit_code};
  wire [31:0] rd_word = rd_ctrl ? ctrl_word :
                        rd_status ? status_word :
                        rd_limit ? limit_word : 32'h0;

  // Write address and data taken in either order, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (aw_hs) begin
        awready <= 1'b0;
        aw_addr <= awaddr;
      end
      if (w_hs) begin
        wready <= 1'b0;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (write_go) begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read data captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (ar_hs) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Control register
  // -----------------------------------------------------------------
  assign fault_clear = ctrl_lane && w_data[CTRL_CLR_BIT];

  // Burst exit forces the target over a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_enable <= 1'b0;
      target_valley <= TARGET_RESET;
    end else begin
      if (ctrl_lane) begin
        ctrl_enable <= w_data[CTRL_EN_BIT];
        target_valley <= w_data[CTRL_TGT_LSB +: 3];
      end
      if (exit_evt) target_valley <= TARGET_RESET;
    end
  end

  // -----------------------------------------------------------------
  // Helpers: limit, short-winding filter, burst entry blanking
  // -----------------------------------------------------------------
  assign lif.zc_code = zc_current_code;
  assign lif.burst = burst_active;
  assign limit_code = lif.limit;

  current_limit u_limit (
    .aclk(aclk),
    .aresetn(aresetn),
    .lif(lif)
  );

  wire short_raw = cs_over_short && gate && !burst_active;

  spike_filter #(.COUNT(WSHORT_BLANK_CYC), .W(8)) u_short (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(short_raw),
    .dout(short_seen)
  );

  wire entry_raw = fb_below_entry && !burst_active &&
                   (target_valley == BURST_ENTRY_VALLEY_COUNT);

  spike_filter #(.COUNT(ENTRY_BLANK), .W(EW)) u_entry (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(entry_raw),
    .dout(entry_ok)
  );

  // -----------------------------------------------------------------
  // Switching decisions
  // -----------------------------------------------------------------
  wire blanked = on_cnt < LEB_L;
  wire rs_len_short = zc_above_rs;
  wire [CW-1:0] rs_len = rs_len_short ? SHORT_RS_L : LONG_RS_L;
  wire rs_done = off_cnt >= rs_len;
  wire valley_ok = valley_counter >= target_valley;
  wire off_timeout = off_cnt >= MAX_OFF_L;
  wire on_timeout = on_cnt >= MAX_ON_L;
  wire fb_trip = !blanked && cs_over_fb;
  wire lim_trip = !blanked && cs_over_limit;
  wire tmr_tick = tmr == PERIOD_L - 1'b1;
  wire duty_over = tmr >= HALF_L;
  wire in_burst = (state == S_PAUSE) || (state == S_BURST_OFF) ||
                  (state == S_BURST_ON);

  assign exit_evt = in_burst && fb_above_exit;

  // Next state: normal valley switching and burst hysteresis
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (ctrl_enable && !short_fault) next_state = S_RING;
      end
      S_RING: begin
        if (entry_ok) next_state = S_PAUSE;
        else if (off_timeout) next_state = S_ON;
        else if (rs_done) next_state = S_WAIT;
      end
      S_WAIT: begin
        if (entry_ok) next_state = S_PAUSE;
        else if (valley_ok || off_timeout) next_state = S_ON;
      end
      S_ON: begin
        if (short_seen) next_state = S_IDLE;
        else if (on_timeout || fb_trip || lim_trip) begin
          next_state = S_RING;
        end
      end
      S_PAUSE: begin
        if (fb_above_exit) next_state = S_RING;
        else if (fb_above_resume) next_state = S_BURST_OFF;
      end
      S_BURST_OFF: begin
        if (fb_above_exit) next_state = S_RING;
        else if (!fb_above_pause) next_state = S_PAUSE;
        else if (tmr_tick) next_state = S_BURST_ON;
      end
      S_BURST_ON: begin
        if (fb_above_exit) next_state = S_RING;
        else if (lim_trip || duty_over || on_timeout) begin
          next_state = S_BURST_OFF;
        end
      end
      default: next_state = S_IDLE;
    endcase
    if (!ctrl_enable) next_state = S_IDLE;
  end

  assign next_gate = (next_state == S_ON) || (next_state == S_BURST_ON);
  assign next_bias = (next_state != S_PAUSE);

  // State, gate and bias registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_IDLE;
      gate <= 1'b0;
      bias_enable <= 1'b1;
      burst_active <= 1'b0;
    end else begin
      state <= next_state;
      gate <= next_gate;
      bias_enable <= next_bias;
      burst_active <= (next_state == S_PAUSE) ||
                      (next_state == S_BURST_OFF) ||
                      (next_state == S_BURST_ON);
    end
  end

  // -----------------------------------------------------------------
  // Counters
  // -----------------------------------------------------------------
  // On and off time, each saturating, each cleared by the other phase
  always_ff @(posedge aclk) begin
    if (!aresetn || !gate) on_cnt <= '0;
    else if (on_cnt != CNT_MAX) on_cnt <= on_cnt + 1'b1;
  end

  // Idle time is not off time: enabling starts a full ring suppression
  always_ff @(posedge aclk) begin
    if (!aresetn || gate || state == S_IDLE) off_cnt <= '0;
    else if (off_cnt != CNT_MAX) off_cnt <= off_cnt + 1'b1;
  end

  // Valley counter: counts falls while off, cleared by gate high
  always_ff @(posedge aclk) begin
    if (!aresetn || gate) valley_counter <= 3'h0;
    else if (zc_falling && valley_counter != VALLEY_MAX) begin
      valley_counter <= valley_counter + 1'b1;
    end
  end

  // Fixed-frequency burst timer, restarted when switching resumes
  always_ff @(posedge aclk) begin
    if (!aresetn || state == S_PAUSE || !in_burst) tmr <= '0;
    else if (tmr_tick) tmr <= '0;
    else tmr <= tmr + 1'b1;
  end

  // -----------------------------------------------------------------
  // Short-winding fault latch, set wins over clear
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) short_fault <= 1'b0;
    else if (short_seen) short_fault <= 1'b1;
    else if (fault_clear) short_fault <= 1'b0;
  end

endmodule : valley_switch_burst_control

// ### tb/switch_properties.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port-level properties of the switching controller
// ---------------------------------------------------------------
module switch_properties
  import qr_pkg::*;
#(
  parameter int MAX_ON = 6000,
  parameter int MAX_OFF = 10000,
  parameter int LONG_RS = 5000,
  parameter int ENTRY_BLANK = 4800000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cs_over_fb,
  input wire logic cs_over_limit,
  input wire logic cs_over_short,
  input wire logic fb_below_entry,
  input wire logic fb_above_resume,
  input wire logic fb_above_pause,
  input wire logic fb_above_exit,
  input wire logic gate,
  input wire logic bias_enable,
  input wire logic [7:0] limit_code,
  input wire logic burst_active,
  input wire logic short_fault
);
  int hi_cnt, lo_cnt, sh_cnt, fb_cnt;
  // Shortest ring suppression either threshold level can select
  localparam int RS_MIN = (SHORT_RS_CYC < LONG_RS) ? SHORT_RS_CYC : LONG_RS;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Run lengths of gate high, gate low, short level and low feedback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_cnt <= 0;
      lo_cnt <= 0;
      sh_cnt <= 0;
      fb_cnt <= 0;
    end else begin
      hi_cnt <= gate ? hi_cnt + 1 : 0;
      lo_cnt <= gate ? 0 : lo_cnt + 1;
      sh_cnt <= cs_over_short ? sh_cnt + 1 : 0;
      fb_cnt <= fb_below_entry ? fb_cnt + 1 : 0;
    end
  end
  AST_RING_HOLD: assert property ($rose(gate) |-> lo_cnt >= RS_MIN)
    else $error("gate rose inside ring suppression");
  AST_BLANK: assert property ($fell(gate) && !short_fault |->
    hi_cnt >= EDGE_BLANK_CYC) else $error("gate pulse below blanking");
  AST_MAX_ON: assert property (hi_cnt <= MAX_ON + 1)
    else $error("gate high beyond max on");
  AST_FB_OFF: assert property (gate && cs_over_fb && !burst_active &&
    hi_cnt >= EDGE_BLANK_CYC + 1 |=> !gate)
    else $error("no turn off on feedback");
  AST_LIMIT_OFF: assert property (gate && cs_over_limit &&
    hi_cnt >= EDGE_BLANK_CYC + 1 |=> !gate)
    else $error("no turn off on current limit");
  AST_SHORT_BLANK: assert property ($rose(short_fault) |->
    sh_cnt >= WSHORT_BLANK_CYC) else $error("short fault too early");
  AST_ENTRY: assert property ($rose(burst_active) |->
    fb_cnt >= ENTRY_BLANK) else $error("burst entered too early");
  AST_RESUME: assert property (!bias_enable && fb_above_resume |->
    ##[1:2] bias_enable) else $error("bias not restored");
  AST_DUTY: assert property (burst_active && gate |->
    hi_cnt <= BURST_PERIOD_CYC / 2 + 2) else $error("burst duty too long");
  AST_PAUSE: assert property (burst_active && !gate && !fb_above_pause &&
    !fb_above_exit |-> ##[1:2] !bias_enable) else $error("no burst pause");
  AST_BURST_LIM: assert property (burst_active && $past(burst_active) &&
    $past(burst_active, 2) |-> limit_code == BURST_LIMIT)
    else $error("wrong burst limit");
  AST_EXIT: assert property (burst_active && fb_above_exit |=>
    !burst_active) else $error("burst not left");
  // Main scenarios reached
  cover property ($rose(burst_active));
  cover property ($rose(short_fault));
  cover property ($fell(gate) && hi_cnt == MAX_ON + 1);
endmodule : switch_properties

// ### tb/switch_sense_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Power stage: sense ramp while on, valley pulses while off
// ---------------------------------------------------------------
module switch_sense_model (
  input wire logic aclk,
  input wire logic gate,
  input wire logic [31:0] ramp,
  input wire logic [31:0] ring,
  output logic cs_over_fb,
  output logic zc_falling
);
  int hi = 0;
  int lo = 0;
  // Ramp of zero never trips; ring of zero gives no valleys
  always @(posedge aclk) begin
    hi = gate ? hi + 1 : 0;
    lo = gate ? 0 : lo + 1;
    cs_over_fb <= ramp != 0 && hi >= ramp;
    zc_falling <= ring != 0 && lo > 0 && lo % ring == 0;
  end
endmodule : switch_sense_model

// ### tb/valley_switch_burst_control_bench.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Self-checking bench
// ---------------------------------------------------------------
module valley_switch_burst_control_bench;
  import qr_pkg::*;
  localparam int P_ON = 2500;
  localparam int P_OFF = 600;
  localparam int P_RS = 100;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] addr;
    logic [1:0] resp;
    logic [31:0] data;
  } row_t;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, zc_falling, zc_above_rs, gate;
  logic cs_over_fb, cs_over_limit, cs_over_short, fb_below_entry;
  logic fb_above_resume, fb_above_pause, fb_above_exit;
  logic bias_enable, burst_active, short_fault;
  logic [7:0] awaddr, araddr, zc_current_code, limit_code;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int ramp, ring, n, h, mismatches, total_checks;
  row_t rows [7] = '{'{8'h00, ADDR_CTRL, RESP_OKAY, 32'h2},
    '{8'h00, ADDR_STATUS, RESP_OKAY, 32'h4},
    '{8'h00, ADDR_LIMIT, RESP_OKAY, 32'hff},
    '{8'h38, ADDR_LIMIT, RESP_OKAY, 32'hef},
    '{8'h58, ADDR_LIMIT, RESP_OKAY, 32'hd5},
    '{8'hff, ADDR_LIMIT, RESP_OKAY, 32'hb9},
    '{8'h00, 8'h0c, RESP_SLVERR, 32'h0}};
  switch_sense_model far (.aclk, .gate, .ramp, .ring, .cs_over_fb,
    .zc_falling);
  valley_switch_burst_control #(.MAX_ON(P_ON), .MAX_OFF(P_OFF),
    .LONG_RS(P_RS), .ENTRY_BLANK(50)) uut (.aclk, .aresetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .zc_falling, .zc_above_rs, .cs_over_fb, .cs_over_limit, .cs_over_short,
    .fb_below_entry, .fb_above_resume, .fb_above_pause, .fb_above_exit,
    .zc_current_code, .gate, .bias_enable, .limit_code, .burst_active,
    .short_fault);
  // Clock and watchdog
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    #400_000;
    mismatches++;
    complete_run();
  end
  // Range compare, exact when both bounds match
  task automatic check(input logic [31:0] got, input logic [31:0] lo,
    input logic [31:0] hi);
    total_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      mismatches++;
      $display("FAIL %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : check
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 50) mismatches++;
    r = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 50) mismatches++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr
  // Edges until gate shows the given level
  task automatic wg(input logic lvl, output int k);
    for (k = 0; k < 20000 && gate !== lvl; k++) @(posedge aclk);
  endtask : wg
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, zc_above_rs} = '0;
    {cs_over_limit, cs_over_short, fb_below_entry, fb_above_resume} = '0;
    {fb_above_pause, fb_above_exit, awaddr, araddr, wdata} = '0;
    {zc_current_code, ramp, ring} = '0;
    wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      zc_current_code <= rows[i].code;
      repeat (3) @(posedge aclk);
      axr(rows[i].addr);
      check(r, rows[i].resp, rows[i].resp);
      check(d, rows[i].data, rows[i].data);
    end
    check({gate, bias_enable, burst_active, short_fault}, 4'h4, 4'h4);
    axw(ADDR_STATUS, 32'hff);
    check(r, RESP_OKAY, RESP_OKAY);
    axw(8'h0c, 32'h1);
    check(r, RESP_SLVERR, RESP_SLVERR);
    axr(ADDR_STATUS);
    check(d, 32'h4, 32'h4);
    ramp <= 100;
    ring <= 20;
    axw(ADDR_CTRL, 32'h3);
    wg(1'b1, n);
    check(n, P_RS - 3, P_RS + 3);
    wg(1'b0, n);
    check(n, 101, 102);
    ramp <= 10;
    wg(1'b1, n);
    wg(1'b0, n);
    check(n, EDGE_BLANK_CYC, EDGE_BLANK_CYC + 2);
    ramp <= 0;
    wg(1'b1, n);
    wg(1'b0, n);
    check(n, P_ON + 1, P_ON + 1);
    cs_over_limit <= 1'b1;
    wg(1'b1, n);
    wg(1'b0, n);
    check(n, EDGE_BLANK_CYC, EDGE_BLANK_CYC + 3);
    cs_over_limit <= 1'b0;
    ring <= 0;
    ramp <= 100;
    wg(1'b1, n);
    check(n, P_OFF - 1, P_OFF + 2);
    ring <= 20;
    axw(ADDR_CTRL, 32'hf);
    wg(1'b0, n);
    wg(1'b1, n);
    check(n, 139, 144);
    axw(ADDR_CTRL, 32'h3);
    zc_above_rs <= 1'b1;
    wg(1'b0, n);
    wg(1'b1, n);
    check(n, SHORT_RS_CYC - 2, SHORT_RS_CYC + 4);
    zc_above_rs <= 1'b0;
    ramp <= 0;
    wg(1'b0, n);
    wg(1'b1, n);
    cs_over_short <= 1'b1;
    repeat (30) @(posedge aclk);
    cs_over_short <= 1'b0;
    wg(1'b0, n);
    check(short_fault, 1'b0, 1'b0);
    wg(1'b1, n);
    cs_over_short <= 1'b1;
    repeat (45) @(posedge aclk);
    check({short_fault, gate}, 2'h2, 2'h2);
    cs_over_short <= 1'b0;
    axw(ADDR_CTRL, 32'h13);
    check(short_fault, 1'b0, 1'b0);
    ramp <= 10;
    axw(ADDR_CTRL, 32'hf);
    fb_below_entry <= 1'b1;
    for (n = 0; n < 3000 && burst_active !== 1'b1; n++) @(posedge aclk);
    check({burst_active, bias_enable}, 2'h2, 2'h2);
    {fb_below_entry, fb_above_pause, fb_above_resume} <= 3'h3;
    repeat (3) @(posedge aclk);
    check(bias_enable, 1'b1, 1'b1);
    wg(1'b1, n);
    wg(1'b0, h);
    check(h, BURST_PERIOD_CYC / 2, BURST_PERIOD_CYC / 2 + 2);
    check(limit_code, BURST_LIMIT, BURST_LIMIT);
    cs_over_limit <= 1'b1;
    wg(1'b1, n);
    check(n + h, BURST_PERIOD_CYC - 1, BURST_PERIOD_CYC + 1);
    wg(1'b0, n);
    check(n, EDGE_BLANK_CYC, EDGE_BLANK_CYC + 3);
    {cs_over_limit, fb_above_pause, fb_above_resume} <= 3'h0;
    h = 0;
    repeat (4000) begin
      @(posedge aclk);
      h += (gate !== 1'b0);
    end
    check({h[30:0], bias_enable}, 32'h0, 32'h0);
    {fb_above_pause, fb_above_resume, fb_above_exit} <= 3'h7;
    repeat (4) @(posedge aclk);
    check({burst_active, limit_code}, 9'hff, 9'hff);
    fb_above_exit <= 1'b0;
    axr(ADDR_CTRL);
    check(d, 32'h3, 32'h3);
    complete_run();
  end
endmodule : valley_switch_burst_control_bench

bind valley_switch_burst_control switch_properties #(.MAX_ON(MAX_ON),
  .MAX_OFF(MAX_OFF), .LONG_RS(LONG_RS), .ENTRY_BLANK(ENTRY_BLANK)) chk (
  .aclk(aclk), .aresetn(aresetn), .cs_over_fb(cs_over_fb),
  .cs_over_limit(cs_over_limit), .cs_over_short(cs_over_short),
  .fb_below_entry(fb_below_entry), .fb_above_resume(fb_above_resume),
  .fb_above_pause(fb_above_pause), .fb_above_exit(fb_above_exit),
  .gate(gate), .bias_enable(bias_enable), .limit_code(limit_code),
  .burst_active(burst_active), .short_fault(short_fault));
